// ==== logic/reset_supervisor.v ====
// Decided for this implementation: the plain strobed port and the placing of the registers.
`include "reset_supervisor_regs.vh"

module reset_supervisor #(
  parameter FILTER_CYCLES = `FILTER_CYCLES,
  parameter EXTEND_COUNT  = `EXTEND_SCLK_PERIODS,
  parameter BLANK_CYCLES  = `BLANK_CYCLES
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Serial clock, sampled
  input  wire        sclk,
  // Detectors, high means fault
  input  wire        v5_low,
  input  wire        v33_low,
  input  wire        core_supply_low,
  input  wire        battery_supply_low,
  input  wire        thermal_shutdown_state,
  input  wire        core_thermal_shutdown,
  // Open-drain reset line
  input  wire        reset_line_in,
  output wire        reset_line_out,
  output wire        reset_line_oe,
  // Safe-state controls
  output wire        miso_oe_allow,
  output wire        step_outputs_off,
  output wire        dc_low_side_on,
  output wire [1:0]  dc_bridge_output_a,
  output wire [1:0]  dc_bridge_output_b,
  output wire        reg5_enable,
  output wire        reg33_enable,
  output wire        core_reg_enable,
  output wire        system_reset,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Interrupt
  output wire        irq
);

  localparam ST_RESET  = 2'h0;
  localparam ST_EXTEND = 2'h1;
  localparam ST_RUN    = 2'h2;

  localparam NSRC = 6;

  wire [NSRC-1:0] raw_fault = {core_thermal_shutdown, thermal_shutdown_state, battery_supply_low,
                               core_supply_low, v33_low, v5_low};

  // Per-source persistence filters, one counter each
  wire [NSRC-1:0] fault_filt;

  fault_filter #(
    .CYCLES (FILTER_CYCLES)
  ) v5_filter_inst (
    .core_clk (core_clk),
    .rst      (rst),
    .fault    (raw_fault[0]),
    .filtered (fault_filt[0])
  );

  fault_filter #(
    .CYCLES (FILTER_CYCLES)
  ) v33_filter_inst (
    .core_clk (core_clk),
    .rst      (rst),
    .fault    (raw_fault[1]),
    .filtered (fault_filt[1])
  );

  fault_filter #(
    .CYCLES (FILTER_CYCLES)
  ) core_filter_inst (
    .core_clk (core_clk),
    .rst      (rst),
    .fault    (raw_fault[2]),
    .filtered (fault_filt[2])
  );

  fault_filter #(
    .CYCLES (FILTER_CYCLES)
  ) batt_filter_inst (
    .core_clk (core_clk),
    .rst      (rst),
    .fault    (raw_fault[3]),
    .filtered (fault_filt[3])
  );

  fault_filter #(
    .CYCLES (FILTER_CYCLES)
  ) thermal_filter_inst (
    .core_clk (core_clk),
    .rst      (rst),
    .fault    (raw_fault[4]),
    .filtered (fault_filt[4])
  );

  fault_filter #(
    .CYCLES (FILTER_CYCLES)
  ) core_thermal_filter_inst (
    .core_clk (core_clk),
    .rst      (rst),
    .fault    (raw_fault[5]),
    .filtered (fault_filt[5])
  );

  wire any_fault = |fault_filt;
  wire thermal   = fault_filt[4] | fault_filt[5];

  // Serial clock rising edge
  reg sclk_q;
  always @(posedge core_clk) begin
    if (rst)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk;
  end
  wire sclk_rise = sclk & ~sclk_q;

  // Reset state machine and extension count
  reg [1:0]  state_q;
  reg [7:0]  ext_cnt_q;
  reg [7:0]  blank_cnt_q;
  reg        line_q;
  reg        drive_q;

  always @(posedge core_clk) begin
    if (rst)
      line_q <= 1'b0;
    else
      line_q <= reset_line_in;
  end

  wire blanked   = blank_cnt_q != 8'h00;
  wire ext_req   = !line_q && !drive_q && !blanked;
  wire line_fall = line_q && !reset_line_in;

  // Blanking reloads while driving and runs out after release
  // Slow open-drain rise must not read as a host pull
  always @(posedge core_clk) begin
    if (rst)
      blank_cnt_q <= 8'h00;
    else if (drive_q)
      blank_cnt_q <= BLANK_CYCLES[7:0];
    else if (blanked)
      blank_cnt_q <= blank_cnt_q - 8'h01;
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_q     <= ST_RESET;
      ext_cnt_q   <= 8'h00;
      drive_q     <= 1'b1;
    end else begin
      case (state_q)
        ST_RESET: begin
          drive_q   <= 1'b1;
          ext_cnt_q <= 8'h00;
          if (!any_fault)
            state_q <= ST_EXTEND;
        end
        ST_EXTEND: begin
          drive_q <= 1'b1;
          if (any_fault) begin
            state_q   <= ST_RESET;
            ext_cnt_q <= 8'h00;
          end else if (sclk_rise) begin
            if (ext_cnt_q == EXTEND_COUNT[7:0] - 8'h01) begin
              state_q <= ST_RUN;
              drive_q <= 1'b0;
            end else begin
              ext_cnt_q <= ext_cnt_q + 8'h01;
            end
          end
        end
        ST_RUN: begin
          if (any_fault) begin
            state_q <= ST_RESET;
            drive_q <= 1'b1;
          end else if (ext_req) begin
            state_q   <= ST_EXTEND;
            drive_q   <= 1'b1;
            ext_cnt_q <= 8'h00;
          end
        end
        default: begin
          state_q <= ST_RESET;
          drive_q <= 1'b1;
        end
      endcase
    end
  end

  assign reset_line_out = 1'b0;
  assign reset_line_oe  = drive_q;

  wire in_reset = drive_q | ~line_q;
  assign system_reset = in_reset;

  // Safe states: thermal shutdown overrides the plain reset pattern
  reg       miso_allow;
  reg       step_off;
  reg       low_side_on;
  reg [1:0] bridge_state;
  reg       main_regs_on;

  always @* begin
    miso_allow   = 1'b1;
    step_off     = 1'b0;
    low_side_on  = 1'b0;
    bridge_state = `BRIDGE_OFF;
    main_regs_on = 1'b1;
    case ({thermal, in_reset})
      2'b01: begin
        miso_allow   = 1'b0;
        step_off     = 1'b1;
        low_side_on  = 1'b1;
        bridge_state = `BRIDGE_LOW_ON;
      end
      2'b10, 2'b11: begin
        miso_allow   = 1'b0;
        step_off     = 1'b1;
        bridge_state = `BRIDGE_OFF;
        main_regs_on = 1'b0;
      end
      default: begin
        miso_allow   = 1'b1;
        bridge_state = `BRIDGE_OFF;
      end
    endcase
  end

  assign miso_oe_allow      = miso_allow;
  assign step_outputs_off   = step_off;
  assign dc_low_side_on     = low_side_on;
  assign dc_bridge_output_a = bridge_state;
  assign dc_bridge_output_b = bridge_state;
  assign reg5_enable        = main_regs_on;
  assign reg33_enable       = main_regs_on;
  assign core_reg_enable    = ~fault_filt[5];

  // Fault word
  reg  [`FLAG_WIDTH-1:0] fault_q;
  reg  [`FLAG_WIDTH-1:0] fault_d;
  wire [`FLAG_WIDTH-1:0] cause = {fault_filt, 1'b0};

  // No reset: the cause must survive the reset it records
  always @* begin
    fault_d = fault_q;
    if (line_fall) begin
      if (!drive_q)
        fault_d = `FAULT_RESET | (7'h01 << `FLAG_EXT);
      else
        fault_d = fault_q | cause;
    end
  end

  always @(posedge core_clk) begin
    fault_q <= fault_d;
  end

  // Data register and interrupts
  reg [15:0]             data_q;
  reg [`FLAG_WIDTH-1:0]  irq_stat_q;
  reg [`FLAG_WIDTH-1:0]  irq_mask_q;
  wire [`FLAG_WIDTH-1:0] ev = line_fall ? (drive_q ? cause : 7'h01) : 7'h00;
  wire                   rd_stat = reg_rd && reg_addr == `REG_IRQ_STATUS;

  always @(posedge core_clk) begin
    if (rst || in_reset) begin
      data_q     <= `DATA_RESET;
      irq_mask_q <= `MASK_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `REG_DATA)
        data_q <= reg_wdata;
      if (reg_addr == `REG_IRQ_MASK)
        irq_mask_q <= reg_wdata[`FLAG_WIDTH-1:0];
    end
  end

  // A new event in the clearing read's cycle wins
  reg [`FLAG_WIDTH-1:0] irq_stat_d;

  always @* begin
    irq_stat_d = irq_stat_q;
    if (rd_stat)
      irq_stat_d = 7'h00;
    irq_stat_d = irq_stat_d | ev;
  end

  always @(posedge core_clk) begin
    if (rst)
      irq_stat_q <= 7'h00;
    else
      irq_stat_q <= irq_stat_d;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read data stand one cycle, zero otherwise
  reg [15:0] rdata_d;

  always @* begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `REG_FAULT_WORD: rdata_d = {9'h000, fault_q};
        `REG_IRQ_STATUS: rdata_d = {9'h000, irq_stat_q};
        `REG_IRQ_MASK:   rdata_d = {9'h000, irq_mask_q};
        `REG_DATA:       rdata_d = data_q;
        `REG_STATE:      rdata_d = {8'h00, ext_cnt_q[5:0], state_q};
        default:         rdata_d = 16'h0000;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (rst)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= rdata_d;
  end

endmodule // reset_supervisor

// Persistence filter for one detector
module fault_filter #(
  parameter CYCLES = `FILTER_CYCLES,
  parameter WIDTH  = 16
) (
  // Clock and reset
  input  wire core_clk,
  input  wire rst,
  // Detector in, filtered fault out
  input  wire fault,
  output reg  filtered
);

  localparam [31:0] LAST = CYCLES - 1;

  reg [WIDTH-1:0] cnt_q;

  // Fault must stand CYCLES edges before it counts
  always @(posedge core_clk) begin
    if (rst) begin
      cnt_q    <= {WIDTH{1'b0}};
      filtered <= 1'b0;
    end else if (!fault) begin
      cnt_q    <= {WIDTH{1'b0}};
      filtered <= 1'b0;
    end else if (cnt_q >= LAST[WIDTH-1:0]) begin
      filtered <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // fault_filter

// ==== include/reset_supervisor_regs.vh ====
`ifndef RESET_SUPERVISOR_REGS_VH
`define RESET_SUPERVISOR_REGS_VH

// Timing
`define CLK_PERIOD_NS        10
`define FILTER_MIN_NS        1500
`define FILTER_MAX_NS        5000
// Filter count: above minimum, below maximum, in core_clk cycles
`define FILTER_CYCLES        ((`FILTER_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 50)
`define EXTEND_SCLK_PERIODS  128
`define BLANK_CYCLES         64

// Fault word bit positions
`define FLAG_EXT             0
`define FLAG_V5_LOW          1
`define FLAG_V33_LOW         2
`define FLAG_CORE_LOW        3
`define FLAG_BATT_LOW        4
`define FLAG_TSD             5
`define FLAG_TSD_CORE        6
`define FLAG_WIDTH           7

// Register offsets
`define REG_FAULT_WORD       4'h0
`define REG_IRQ_STATUS       4'h1
`define REG_IRQ_MASK         4'h2
`define REG_DATA             4'h3
`define REG_STATE            4'h4

// Reset values
`define FAULT_RESET          7'h00
`define MASK_RESET           7'h00
`define DATA_RESET           16'h0000

// Bridge encodings
`define BRIDGE_LOW_ON        2'h0
`define BRIDGE_HIGH_ON       2'h1
`define BRIDGE_OFF           2'h2

`endif

// ==== verification/host_cpu_model.sv ====
module host_cpu_model (
  // Host request and device pull
  input wire pull_req,
  input wire dev_oe,
  // Wired line with pull-up
  output wire line_level
);
  timeunit 1ns;
  timeprecision 1ns;
  assign line_level = !(dev_oe || pull_req);
endmodule // host_cpu_model

// ==== verification/reset_supervisor_sva.sv ====
module reset_supervisor_sva #(parameter FILTER_CYCLES = 20, EXTEND_COUNT = 16, BLANK_CYCLES = 8) (
  // Clock, reset, detectors
  input wire core_clk, rst, sclk, v5_low, v33_low, core_supply_low, battery_supply_low, thermal_shutdown_state,
  // Reset line and safe state
  input wire reset_line_in, reset_line_out, reset_line_oe, miso_oe_allow, step_outputs_off, dc_low_side_on,
  input wire reg5_enable, reg33_enable, core_reg_enable, system_reset,
  input wire [1:0] dc_bridge_output_a, dc_bridge_output_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire any_f = v5_low | v33_low | core_supply_low | battery_supply_low | thermal_shutdown_state;
  int f_q, x_q, q_q;
  logic sclk_q;
  // Fault age, sclk rises since last disturbance, cycles since release
  always @(posedge core_clk) begin
    sclk_q <= sclk;
    f_q <= (any_f && !rst) ? f_q + 1 : 0;
    x_q <= (rst || any_f || !(reset_line_in || reset_line_oe)) ? 0 : x_q + 32'(sclk && !sclk_q);
    q_q <= reset_line_oe ? 0 : q_q + 1;
  end
  sequence s_host_pull;
    $fell(reset_line_in) && !reset_line_oe && q_q > BLANK_CYCLES;
  endsequence
  AST_OPEN_DRAIN: assert property (reset_line_out == 1'b0) else $error("line driven high");
  AST_HOLD: assert property (reset_line_oe |-> system_reset) else $error("reset not held");
  AST_FILTER: assert property (f_q > FILTER_CYCLES + 2 |-> reset_line_oe) else $error("fault ignored");
  AST_EXTEND: assert property ($fell(reset_line_oe) |-> x_q >= EXTEND_COUNT - 1) else $error("early release");
  AST_HOST: assert property (s_host_pull |-> ##[1:4] reset_line_oe) else $error("host reset missed");
  AST_SAFE: assert property (system_reset && reg5_enable |-> !miso_oe_allow && step_outputs_off &&
    dc_low_side_on && dc_bridge_output_a == 2'h0) else $error("unsafe outputs");
  AST_TSD: assert property (!reg5_enable |-> dc_bridge_output_b == 2'h2 && step_outputs_off ##[0:1] system_reset)
    else $error("thermal state wrong");
  AST_REGS: assert property (reg5_enable == reg33_enable && (core_reg_enable || !reg5_enable))
    else $error("regulator enables wrong");
endmodule // reset_supervisor_sva
bind reset_supervisor reset_supervisor_sva #(.FILTER_CYCLES(FILTER_CYCLES), .EXTEND_COUNT(EXTEND_COUNT),
  .BLANK_CYCLES(BLANK_CYCLES)) sva_inst (.core_clk(core_clk), .rst(rst), .sclk(sclk), .v5_low(v5_low),
  .v33_low(v33_low), .core_supply_low(core_supply_low), .battery_supply_low(battery_supply_low),
  .thermal_shutdown_state(thermal_shutdown_state), .reset_line_in(reset_line_in),
  .reset_line_out(reset_line_out), .reset_line_oe(reset_line_oe), .miso_oe_allow(miso_oe_allow),
  .step_outputs_off(step_outputs_off), .dc_low_side_on(dc_low_side_on), .reg5_enable(reg5_enable),
  .reg33_enable(reg33_enable), .core_reg_enable(core_reg_enable), .system_reset(system_reset),
  .dc_bridge_output_a(dc_bridge_output_a), .dc_bridge_output_b(dc_bridge_output_b));

// ==== verification/reset_supervisor_test.sv ====
`include "reset_supervisor_regs.vh"
module reset_supervisor_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FC = 20, XC = 16;
  logic core_clk = 0, rst = 1, sclk = 0, reg_wr = 0, reg_rd = 0, pull_req = 0;
  logic v5_low = 0, v33_low = 0, core_supply_low = 0, battery_supply_low = 0;
  logic thermal_shutdown_state = 0, core_thermal_shutdown = 0;
  logic [3:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, d, v;
  wire reset_line_in, reset_line_out, reset_line_oe, miso_oe_allow, step_outputs_off, dc_low_side_on;
  wire reg5_enable, reg33_enable, core_reg_enable, system_reset, irq;
  wire [1:0] dc_bridge_output_a, dc_bridge_output_b;
  wire [15:0] reg_rdata;
  int n_errors = 0, samples_checked = 0, exp_flags, exp_stat, i, k;
  reset_supervisor #(.FILTER_CYCLES(FC), .EXTEND_COUNT(XC), .BLANK_CYCLES(8)) reset_supervisor_inst (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .v5_low(v5_low), .v33_low(v33_low),
    .core_supply_low(core_supply_low), .battery_supply_low(battery_supply_low),
    .thermal_shutdown_state(thermal_shutdown_state), .core_thermal_shutdown(core_thermal_shutdown),
    .reset_line_in(reset_line_in), .reset_line_out(reset_line_out), .reset_line_oe(reset_line_oe),
    .miso_oe_allow(miso_oe_allow), .step_outputs_off(step_outputs_off), .dc_low_side_on(dc_low_side_on),
    .dc_bridge_output_a(dc_bridge_output_a), .dc_bridge_output_b(dc_bridge_output_b),
    .reg5_enable(reg5_enable), .reg33_enable(reg33_enable), .core_reg_enable(core_reg_enable),
    .system_reset(system_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  host_cpu_model host_cpu_model_inst (.pull_req(pull_req), .dev_oe(reset_line_oe), .line_level(reset_line_in));
  initial forever #5 core_clk = ~core_clk;
  initial forever #20 sclk = ~sclk;
  initial begin
    #100us;
    n_errors++;
    end_sim();
  end
  task automatic end_sim();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic setf(input logic [5:0] f);
    {core_thermal_shutdown, thermal_shutdown_state, battery_supply_low, core_supply_low, v33_low, v5_low} <= f;
  endtask
  // One-cycle write or read, data taken in the following cycle
  task automatic rw(input logic wr, input logic [3:0] a, input logic [15:0] w);
    tick(1);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= w;
    tick(1);
    reg_wr <= 0;
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task automatic rel();
    for (k = 0; reset_line_oe !== 1'b0 && k < 3000; k++) tick(1);
    chk(16'(k > XC * 4 - 8 && k < XC * 4 + 60), 1);
  endtask
  task automatic host();
    tick(20);
    pull_req <= 1;
    tick(5 + $urandom_range(0, 4));
    chk(reset_line_oe, 1);
    pull_req <= 0;
    rel();
    exp_flags = 1;
    rw(0, `REG_FAULT_WORD, 0);
    chk(d, 16'(exp_flags));
  endtask
  initial begin
    void'($urandom(79410));
    tick(6);
    rst <= 0;
    rw(1, `REG_DATA, 16'hffff);
    rel();
    rw(0, `REG_DATA, 0);
    chk(d, `DATA_RESET);
    $display("test 1 done");
    v = $urandom;
    rw(1, `REG_DATA, v);
    rw(0, `REG_DATA, 0);
    chk(d, v);
    host();
    rw(0, `REG_DATA, 0);
    chk(d, `DATA_RESET);
    $display("test 2 done");
    setf(6'h01);
    tick(FC / 2);
    setf(6'h00);
    tick(10);
    chk(reset_line_oe, 0);
    $display("test 3 done");
    for (i = 0; i < 6; i++) begin
      setf(i == 5 ? 6'h30 : 6'(1 << i));
      exp_flags |= i == 5 ? 'h60 : 2 << i;
      tick(FC + 10 + $urandom_range(0, 20));
      chk(reset_line_oe, 1);
      chk(dc_bridge_output_a, i > 3 ? `BRIDGE_OFF : `BRIDGE_LOW_ON);
      chk(core_reg_enable, i != 5);
      setf(6'h00);
      rel();
      rw(0, `REG_FAULT_WORD, 0);
      chk(d, 16'(exp_flags));
    end
    exp_stat = exp_flags;
    $display("test 4 done");
    host();
    chk(irq, 0);
    rw(1, `REG_IRQ_MASK, 16'h007f);
    chk(irq, 1);
    rw(0, `REG_IRQ_STATUS, 0);
    chk(d, 16'(exp_stat | 1));
    chk(irq, 0);
    rw(0, 4'hf, 0);
    chk(d, 0);
    $display("test 5 done");
    end_sim();
  end
endmodule // reset_supervisor_test
